// File: common/ssio_pkg.sv
// Shared constants for the shared segment I/O port block
package ssio_pkg;
	// Port width
	localparam int PORT_W = 8;
	// Bus and segment-select field widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int SGS_W  = 4;

	// Register byte addresses
	localparam logic [15:0] ADDR_LATCH6   = 16'hFFD9;
	localparam logic [15:0] ADDR_LATCH7   = 16'hFFDA;
	localparam logic [15:0] ADDR_PULLUP5  = 16'hFFE2;
	localparam logic [15:0] ADDR_PULLUP6  = 16'hFFE3;
	localparam logic [15:0] ADDR_DIR6     = 16'hFFE9;
	localparam logic [15:0] ADDR_DIR7     = 16'hFFEA;

	// Reset values
	localparam logic [7:0] RST_LATCH6  = 8'h00;
	localparam logic [7:0] RST_LATCH7  = 8'h00;
	localparam logic [7:0] RST_PULLUP5 = 8'h00;
	localparam logic [7:0] RST_PULLUP6 = 8'h00;
	localparam logic [7:0] RST_DIR6    = 8'h00;
	localparam logic [7:0] RST_DIR7    = 8'h00;
	localparam logic [7:0] RST_RDATA   = 8'h00;

	// Read answers that hold no stored state
	localparam logic [7:0] RD_WRITE_ONLY = 8'hFF;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// Segment-select values below these free a port for general use
	localparam logic [3:0] GPIO_LIMIT6 = 4'h8;
	localparam logic [3:0] GPIO_LIMIT7 = 4'h4;

	// Bus access kinds
	typedef enum logic [1:0] {
		SSIO_ACC_IDLE,
		SSIO_ACC_WRITE,
		SSIO_ACC_READ
	} ssio_acc_t;
endpackage

// File: verilog/ssio_pullup.sv
// Input pull-up control for one port
`timescale 1ns/100ps
module ssio_pullup #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] direction,
	input  wire logic [WIDTH-1:0] enable,
	output logic      [WIDTH-1:0] pullup_on
);
	genvar i;

	// One pull-up per pin, on only for an input with enable set
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// Output pins never pull up
			assign pullup_on[i] = ~direction[i] & enable[i];
		end
	endgenerate
endmodule

// File: verilog/ssio_pin_mux.sv
// Pin driver select for one shared segment port
`timescale 1ns/100ps
module ssio_pin_mux #(
	parameter int WIDTH = 8
) (
	input  wire logic             gpio_free,
	input  wire logic             standby,
	input  wire logic [WIDTH-1:0] direction,
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] segment,
	input  wire logic [WIDTH-1:0] pullup_on,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe
);
	genvar i;

	// Per-pin choice between low power, segment and general use
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			always_comb begin
				if (standby) begin
					// Floating, or held high by the pull-up
					pin_out[i] = 1'b1;
					pin_oe[i]  = pullup_on[i];
				end else if (!gpio_free) begin
					// Segment owns the pin, port bits ignored
					pin_out[i] = segment[i];
					pin_oe[i]  = 1'b1;
				end else begin
					// General use: direction picks drive
					pin_out[i] = latch[i];
					pin_oe[i]  = direction[i];
				end
			end
		end
	endgenerate
endmodule

// File: verilog/ssio_ports.sv
// Shared segment I/O ports: registers, read-back and pin control
//
// Functional notes
// - Output bit reads back the latch
// - Input bit reads back the pin
// - Direction one drives, zero receives
// - Port bits count only in general use
// - Second-port direction reads all ones
// - Reset clears latch, direction, pull-up enable
// - Pull-up only for enabled input pins
// - Pull-up enable register reads back
// - First-port pull-ups off after reset
// - First-port pull-up needs input and enable
// - Low power floats, pull-up drives high
// - Third-port read: latch or pin by direction
// - Third-port direction one drives, zero receives
// - Third-port bits count only in general use
// - Third-port direction reads all ones
// - Reset clears third-port latch and direction
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module ssio_ports #(
	parameter int PORT_W = ssio_pkg::PORT_W
) (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic [ssio_pkg::ADDR_W-1:0]  bus_addr,
	input  wire logic [ssio_pkg::DATA_W-1:0]  bus_wdata,
	input  wire logic                         bus_write,
	input  wire logic                         bus_read,
	output logic      [ssio_pkg::DATA_W-1:0]  bus_rdata,
	input  wire logic [ssio_pkg::SGS_W-1:0]   segment_select_field,
	input  wire logic                         standby_mode,
	input  wire logic [PORT_W-1:0]            lcd_segment_output6,
	input  wire logic [PORT_W-1:0]            lcd_segment_output7,
	input  wire logic [PORT_W-1:0]            port5_direction,
	output logic      [PORT_W-1:0]            port5_pullup_on,
	output logic      [PORT_W-1:0]            port6_pullup_on,
	input  wire logic [PORT_W-1:0]            second_port_pin_in,
	output logic      [PORT_W-1:0]            second_port_pin_out,
	output logic      [PORT_W-1:0]            second_port_pin_oe,
	input  wire logic [PORT_W-1:0]            third_port_pin_in,
	output logic      [PORT_W-1:0]            third_port_pin_out,
	output logic      [PORT_W-1:0]            third_port_pin_oe
);
	// Stored port state
	logic [PORT_W-1:0]           port6_output_latch;  // Second-port data
	logic [PORT_W-1:0]           port7_output_latch;  // Third-port data
	logic [PORT_W-1:0]           port6_direction;     // Second-port direction
	logic [PORT_W-1:0]           port7_direction;     // Third-port direction
	logic [PORT_W-1:0]           port6_pullup_enable; // Second-port pull-ups
	logic [PORT_W-1:0]           port5_pullup_enable; // First-port pull-ups
	// Decoded bus access
	ssio_pkg::ssio_acc_t         access;              // Kind of this cycle
	logic [ssio_pkg::DATA_W-1:0] next_rdata;          // Read answer
	// Segment-select decode
	logic                        gpio_free6;          // Second port in general use
	logic                        gpio_free7;          // Third port in general use

	// True while the select field leaves the port's pins to general use
	function automatic logic ssio_gpio_free(
		input logic [ssio_pkg::SGS_W-1:0] sgs,
		input logic [ssio_pkg::SGS_W-1:0] limit
	);
		ssio_gpio_free = (sgs < limit);
	endfunction

	// Mixed read-back: latch for output bits, pin for input bits
	function automatic logic [PORT_W-1:0] ssio_port_read(
		input logic [PORT_W-1:0] dir,
		input logic [PORT_W-1:0] latch,
		input logic [PORT_W-1:0] pin
	);
		ssio_port_read = (dir & latch) | (~dir & pin);
	endfunction

	// Classify the bus cycle; strobes never come together
	always_comb begin
		if (bus_write) begin
			access = ssio_pkg::SSIO_ACC_WRITE;
		end else if (bus_read) begin
			access = ssio_pkg::SSIO_ACC_READ;
		end else begin
			access = ssio_pkg::SSIO_ACC_IDLE;
		end
	end

	// Port ownership from the segment-select field
	assign gpio_free6 = ssio_gpio_free(segment_select_field, ssio_pkg::GPIO_LIMIT6);
	assign gpio_free7 = ssio_gpio_free(segment_select_field, ssio_pkg::GPIO_LIMIT7);

	// Second-port data latch
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port6_output_latch <= ssio_pkg::RST_LATCH6;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_LATCH6) begin
			// Stored even while segments own the pins
			port6_output_latch <= bus_wdata;
		end
	end

	// Third-port data latch
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port7_output_latch <= ssio_pkg::RST_LATCH7;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_LATCH7) begin
			port7_output_latch <= bus_wdata;
		end
	end

	// Second-port direction, write only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port6_direction <= ssio_pkg::RST_DIR6;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_DIR6) begin
			// Each bit acts on its own pin
			port6_direction <= bus_wdata;
		end
	end

	// Third-port direction, write only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port7_direction <= ssio_pkg::RST_DIR7;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_DIR7) begin
			port7_direction <= bus_wdata;
		end
	end

	// Second-port pull-up enables
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port6_pullup_enable <= ssio_pkg::RST_PULLUP6;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_PULLUP6) begin
			port6_pullup_enable <= bus_wdata;
		end
	end

	// First-port pull-up enables; first port's own logic lives elsewhere
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			// All first-port pull-ups start off
			port5_pullup_enable <= ssio_pkg::RST_PULLUP5;
		end else if (access == ssio_pkg::SSIO_ACC_WRITE
			&& bus_addr == ssio_pkg::ADDR_PULLUP5) begin
			port5_pullup_enable <= bus_wdata;
		end
	end

	// Read answer for the addressed location
	always_comb begin
		case (bus_addr)
			ssio_pkg::ADDR_LATCH6: begin
				// Pins sampled directly; they are synchronous
				next_rdata = ssio_port_read(port6_direction,
					port6_output_latch, second_port_pin_in);
			end
			ssio_pkg::ADDR_LATCH7: begin
				next_rdata = ssio_port_read(port7_direction,
					port7_output_latch, third_port_pin_in);
			end
			ssio_pkg::ADDR_PULLUP6: begin
				next_rdata = port6_pullup_enable;
			end
			ssio_pkg::ADDR_PULLUP5: begin
				next_rdata = port5_pullup_enable;
			end
			ssio_pkg::ADDR_DIR6: begin
				// Direction is not readable
				next_rdata = ssio_pkg::RD_WRITE_ONLY;
			end
			ssio_pkg::ADDR_DIR7: begin
				next_rdata = ssio_pkg::RD_WRITE_ONLY;
			end
			default: begin
				// Unmapped location
				next_rdata = ssio_pkg::RD_UNMAPPED;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bus_rdata <= ssio_pkg::RST_RDATA;
		end else if (access == ssio_pkg::SSIO_ACC_READ) begin
			bus_rdata <= next_rdata;
		end else begin
			bus_rdata <= ssio_pkg::RD_UNMAPPED;
		end
	end

	// First-port pull-ups from its direction and enables
	ssio_pullup #(
		.WIDTH     (PORT_W)
	) u_pullup5 (
		.direction (port5_direction),
		.enable    (port5_pullup_enable),
		.pullup_on (port5_pullup_on)
	);

	// Second-port pull-ups
	ssio_pullup #(
		.WIDTH     (PORT_W)
	) u_pullup6 (
		.direction (port6_direction),
		.enable    (port6_pullup_enable),
		.pullup_on (port6_pullup_on)
	);

	// Second-port pin driver, pull-up holds pin in low power
	ssio_pin_mux #(
		.WIDTH     (PORT_W)
	) u_mux6 (
		.gpio_free (gpio_free6),
		.standby   (standby_mode),
		.direction (port6_direction),
		.latch     (port6_output_latch),
		.segment   (lcd_segment_output6),
		.pullup_on (port6_pullup_on),
		.pin_out   (second_port_pin_out),
		.pin_oe    (second_port_pin_oe)
	);

	// Third-port pin driver; no pull-ups on this port
	ssio_pin_mux #(
		.WIDTH     (PORT_W)
	) u_mux7 (
		.gpio_free (gpio_free7),
		.standby   (standby_mode),
		.direction (port7_direction),
		.latch     (port7_output_latch),
		.segment   (lcd_segment_output7),
		.pullup_on ({PORT_W{1'b0}}),
		.pin_out   (third_port_pin_out),
		.pin_oe    (third_port_pin_oe)
	);

	// Second-port direction location answers all ones
	dir6_read_ones_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_read && bus_addr == ssio_pkg::ADDR_DIR6 |=> bus_rdata == 8'hFF)
	else $error("second-port direction read not all ones");

	// Third-port direction location answers all ones
	dir7_read_ones_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_read && bus_addr == ssio_pkg::ADDR_DIR7 |=> bus_rdata == 8'hFF)
	else $error("third-port direction read not all ones");

	// Second-port read mixes latch and pin by direction
	port6_read_mix_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_read && bus_addr == ssio_pkg::ADDR_LATCH6 |=>
		bus_rdata == (($past(port6_direction) & $past(port6_output_latch))
		| (~$past(port6_direction) & $past(second_port_pin_in))))
	else $error("second-port read-back wrong");

	// Third-port read mixes latch and pin by direction
	port7_read_mix_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_read && bus_addr == ssio_pkg::ADDR_LATCH7 |=>
		bus_rdata == (($past(port7_direction) & $past(port7_output_latch))
		| (~$past(port7_direction) & $past(third_port_pin_in))))
	else $error("third-port read-back wrong");

	// Written latch value is present on the next edge
	latch_write_lands_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_write && bus_addr == ssio_pkg::ADDR_LATCH6 |=>
		port6_output_latch == $past(bus_wdata))
	else $error("second-port latch write lost");

	// Pull-up enable reads back what was written
	pullup_readback_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		bus_write && bus_addr == ssio_pkg::ADDR_PULLUP6 ##1
		bus_read && bus_addr == ssio_pkg::ADDR_PULLUP6 |=>
		bus_rdata == $past(bus_wdata, 2))
	else $error("pull-up enable read-back wrong");

	// Second-port pull-up never on an output pin
	pullup6_input_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		(port6_pullup_on & port6_direction) == 8'h00
		&& (port6_pullup_on | ~port6_pullup_enable | port6_direction) == 8'hFF)
	else $error("second-port pull-up gating wrong");

	// First-port pull-up only for enabled inputs
	pullup5_input_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		port5_pullup_on == (~port5_direction & port5_pullup_enable))
	else $error("first-port pull-up gating wrong");

	// Registers are clear right after reset release
	reset_clear_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		$past(reset) && !$past(bus_write) |->
		port6_output_latch == 8'h00 && port6_direction == 8'h00
		&& port6_pullup_enable == 8'h00 && port7_output_latch == 8'h00
		&& port7_direction == 8'h00 && port5_pullup_on == 8'h00)
	else $error("registers not clear after reset");

	// Segment ownership drives all third-port pins from the segments
	segment_owns_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		!standby_mode && segment_select_field >= 4'h4 |->
		third_port_pin_oe == 8'hFF && third_port_pin_out == lcd_segment_output7)
	else $error("segment pins not driven by segments");

	// General use: third-port enable follows direction
	gpio7_drive_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		!standby_mode && segment_select_field < 4'h4 |->
		third_port_pin_oe == port7_direction
		&& ((third_port_pin_out ^ port7_output_latch) & port7_direction) == 8'h00)
	else $error("third-port drive does not follow direction");

	// Low power: second port floats unless pulled high
	standby_float_a:
	assert property (@(posedge clk_sys) disable iff (reset)
		standby_mode |-> second_port_pin_oe == port6_pullup_on
		&& second_port_pin_out == 8'hFF)
	else $error("second-port low-power state wrong");
endmodule

// File: dv/ssio_board_model.sv
// Board-side model of eight port pins: external drivers and floating levels
`timescale 1ns/100ps
module ssio_board_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pullup_on,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	logic [7:0] last = 8'h00; // Level seen on the previous cycle

	// Pin level: chip drive first, then board drive, then pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pullup_on[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last[i]; // Undriven pin drifts every cycle
		end
	end

	// History for the drifting level
	always_ff @(posedge clk_sys) begin
		last <= pin_in;
	end
endmodule

// File: dv/ssio_ports_bench.sv
// Self-checking bench for the shared segment I/O ports
`timescale 1ns/100ps
module ssio_ports_bench;
	logic        clk_sys  = 1'b0;
	logic        reset    = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0]  bus_wdata = 8'h00;
	logic        bus_write = 1'b0;
	logic        bus_read  = 1'b0;
	logic [7:0]  bus_rdata;
	logic [3:0]  sgs      = 4'h0;
	logic        standby  = 1'b0;
	logic [7:0]  p5_dir   = 8'h00;
	logic [7:0]  p5_on, p6_on;
	logic [7:0]  p6_in, p6_out, p6_oe, p7_in, p7_out, p7_oe;
	logic [7:0]  ext6_en  = 8'h00;
	logic [7:0]  ext6_val = 8'h00;
	logic [7:0]  ext7_en  = 8'h00;
	logic [7:0]  ext7_val = 8'h00;
	int          mismatches = 0;
	int          n_tests    = 0;
	int          cycles     = 0;

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	ssio_ports uut (.clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
		.bus_rdata(bus_rdata), .segment_select_field(sgs), .standby_mode(standby),
		.lcd_segment_output6(8'h96), .lcd_segment_output7(8'h69),
		.port5_direction(p5_dir), .port5_pullup_on(p5_on), .port6_pullup_on(p6_on),
		.second_port_pin_in(p6_in), .second_port_pin_out(p6_out),
		.second_port_pin_oe(p6_oe), .third_port_pin_in(p7_in),
		.third_port_pin_out(p7_out), .third_port_pin_oe(p7_oe));

	ssio_board_model b6 (.clk_sys(clk_sys), .pin_out(p6_out), .pin_oe(p6_oe),
		.pullup_on(p6_on), .ext_en(ext6_en), .ext_val(ext6_val), .pin_in(p6_in));
	// Third port has no pull-up of its own
	ssio_board_model b7 (.clk_sys(clk_sys), .pin_out(p7_out), .pin_oe(p7_oe),
		.pullup_on(8'h00), .ext_en(ext7_en), .ext_val(ext7_val), .pin_in(p7_in));

	// Closing report
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict;
		end
	end

	// Compare one byte
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle bus write, outputs settled on return
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_write <= 1'b1;
		@(posedge clk_sys);
		bus_write <= 1'b0;
		#1;
	endtask

	// One-cycle bus read, data taken in the following cycle
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clk_sys);
		bus_read <= 1'b0;
		#1;
		chk(bus_rdata, exp);
	endtask

	// Pulse reset for three cycles
	task automatic do_reset;
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
	endtask

	// Reset values and access kinds
	task automatic t_reset;
		chk(p7_oe, 8'h00);
		chk(p6_on, 8'h00);
		rd_chk(ssio_pkg::ADDR_PULLUP6, 8'h00);
		rd_chk(ssio_pkg::ADDR_DIR6, 8'hFF);
		rd_chk(ssio_pkg::ADDR_DIR7, 8'hFF);
		rd_chk(16'hFFF0, 8'h00);
		wr(ssio_pkg::ADDR_DIR6, 8'hFF);
		wr(ssio_pkg::ADDR_DIR7, 8'hFF);
		chk(p6_oe, 8'hFF);
		rd_chk(ssio_pkg::ADDR_LATCH6, 8'h00);
		rd_chk(ssio_pkg::ADDR_LATCH7, 8'h00);
		$display("reset test done");
	endtask

	// Mixed direction read-back on both ports
	task automatic t_readback;
		ext6_en <= 8'h0F;
		ext6_val <= 8'h3C;
		ext7_en <= 8'hC3;
		ext7_val <= 8'hC3;
		wr(ssio_pkg::ADDR_DIR6, 8'hF0);
		wr(ssio_pkg::ADDR_LATCH6, 8'hA5);
		chk(p6_oe, 8'hF0);
		chk(p6_out & p6_oe, 8'hA0);
		rd_chk(ssio_pkg::ADDR_LATCH6, 8'hAC);
		rd_chk(ssio_pkg::ADDR_DIR6, 8'hFF);
		wr(ssio_pkg::ADDR_DIR7, 8'h3C);
		chk(p7_oe, 8'h3C);
		wr(ssio_pkg::ADDR_LATCH7, 8'h5A);
		chk(p7_out & p7_oe, 8'h18);
		rd_chk(ssio_pkg::ADDR_LATCH7, 8'hDB);
		$display("read-back test done");
	endtask

	// Pull-up control on first and second ports, then a mid-run reset
	task automatic t_pullup;
		wr(ssio_pkg::ADDR_PULLUP6, 8'hFF);
		chk(p6_on, 8'h0F);
		rd_chk(ssio_pkg::ADDR_PULLUP6, 8'hFF);
		wr(ssio_pkg::ADDR_PULLUP6, 8'h5A);
		chk(p6_on, 8'h0A);
		rd_chk(ssio_pkg::ADDR_PULLUP6, 8'h5A);
		// Write then read with no gap between the strobes
		@(posedge clk_sys);
		bus_addr <= ssio_pkg::ADDR_PULLUP6;
		bus_wdata <= 8'h3C;
		bus_write <= 1'b1;
		@(posedge clk_sys);
		bus_write <= 1'b0;
		bus_read <= 1'b1;
		@(posedge clk_sys);
		bus_read <= 1'b0;
		#1;
		chk(bus_rdata, 8'h3C);
		chk(p6_on, 8'h0C);
		// Read data stands for one cycle only
		@(posedge clk_sys);
		#1;
		chk(bus_rdata, 8'h00);
		// First-port direction changes on a clock edge
		@(posedge clk_sys);
		p5_dir <= 8'h33;
		wr(ssio_pkg::ADDR_PULLUP5, 8'hFF);
		chk(p5_on, 8'hCC);
		rd_chk(ssio_pkg::ADDR_PULLUP5, 8'hFF);
		do_reset;
		chk(p5_on, 8'h00);
		rd_chk(ssio_pkg::ADDR_PULLUP5, 8'h00);
		chk(p6_on, 8'h00);
		$display("pull-up test done");
	endtask

	// Every segment-select value against both ports
	task automatic t_segment;
		wr(ssio_pkg::ADDR_DIR6, 8'h0F);
		wr(ssio_pkg::ADDR_LATCH6, 8'h55);
		wr(ssio_pkg::ADDR_DIR7, 8'hF0);
		wr(ssio_pkg::ADDR_LATCH7, 8'hAA);
		ext6_en <= 8'hF0;
		ext7_en <= 8'h0F;
		for (int s = 0; s < 16; s++) begin
			@(posedge clk_sys);
			sgs <= 4'(s);
			#1;
			chk(p6_oe, (s < 8) ? 8'h0F : 8'hFF);
			chk(p6_out & p6_oe, (s < 8) ? 8'h05 : 8'h96);
			chk(p7_oe, (s < 4) ? 8'hF0 : 8'hFF);
			chk(p7_out & p7_oe, (s < 4) ? 8'hA0 : 8'h69);
		end
		@(posedge clk_sys);
		sgs <= 4'h0;
		$display("segment test done");
	endtask

	// Low-power pin states
	task automatic t_standby;
		wr(ssio_pkg::ADDR_PULLUP6, 8'hFF);
		@(posedge clk_sys);
		standby <= 1'b1;
		#1;
		chk(p6_oe, 8'hF0);
		chk(p6_out & p6_oe, 8'hF0);
		chk(p7_oe, 8'h00);
		@(posedge clk_sys);
		standby <= 1'b0;
		$display("standby test done");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		t_reset;
		t_readback;
		t_pullup;
		t_segment;
		t_standby;
		print_verdict;
	end
endmodule
